// ---- src/sgq_top.sv ----
// serial gas query interpreter: frame parser, control letters, measurement reply
// assumes an axi4-lite master on aclk and a uart that moves bytes on aclk
// Function
// - control letters act only service off, option fitted
// - letters N, K, M select zero, span, sample
// - control frame: stx, code, address, letter, terminator
// - optional address must match; spaces may follow
// - bad frames and foreign addresses get no answer
// - valid measurement request starts a reply when the transmitter is idle
// - request without address: any space is invalid
// - request valid only with good frame, and good checksum when etx-terminated
// - reply: stx, code, count, groups, terminator
// - reply terminator mirrors the request terminator
// - two count digits give the group count
// - group addresses count up by one each
// - value: signed four-digit mantissa, signed two-digit exponent
// - status: operating hex, space, error hex
// - error bits listed upward; bit 7 zero
// - operating bits 0-4 are condition flags
// - operating bits 5-7 hold cylinder number
// - reserved field is ten zero characters
// - groups report co, co2, no, no2, nox, so2, o2
// - etx is followed by exactly two checksum characters
// - checksum sent as two hex characters, high first
`timescale 1ns/1ps
module sgq_top #(
  parameter int NUM_GROUPS = sgq_pkg::NUM_VALUES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic [1:0] gas_mode
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? (sgq_pkg::CH_ZERO + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    // bit 4 marks a character that is not a hex digit
    if (c >= 8'h30 && c <= 8'h39) hex_val = {1'b0, c[3:0]};
    else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) hex_val = {1'b0, c[3:0] + 4'h9};
    else hex_val = 5'h10;
  endfunction
  function automatic logic [11:0] bcd_inc(input logic [11:0] b);
    logic [11:0] r;
    r = b;
    if (r[3:0] != 4'h9) r[3:0] = r[3:0] + 4'h1;
    else begin
      r[3:0] = 4'h0;
      if (r[7:4] != 4'h9) r[7:4] = r[7:4] + 4'h1;
      else begin
        r[7:4] = 4'h0;
        r[11:8] = (r[11:8] == 4'h9) ? 4'h0 : r[11:8] + 4'h1;
      end
    end
    bcd_inc = r;
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [11:0] cfg_addr;
  logic cfg_service;
  logic cfg_zsopt;
  logic [2:0] cfg_count;
  logic [7:0] op_status;
  logic [7:0] err_status;
  logic [31:0] values [NUM_GROUPS];
  logic [7:0] drop_count;
  logic wr_go;
  logic [7:0] wr_off;
  logic wr_hit;
  logic [7:0] rd_off;

  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_off = s_axi_awaddr[7:0];
  assign rd_off = s_axi_araddr[7:0];
  assign wr_hit = (s_axi_awaddr[31:8] == 24'h0) && (wr_off == sgq_pkg::REG_CONFIG ||
    wr_off == sgq_pkg::REG_STATUS_BYTES || wr_off == sgq_pkg::REG_STATE ||
    (wr_off >= sgq_pkg::REG_VALUE_BASE && wr_off < sgq_pkg::REG_VALUE_BASE + 8'(4 * NUM_GROUPS) &&
    wr_off[1:0] == 2'h0));

  always_ff @(posedge aclk) begin
    logic [31:0] m;
    m = 32'h0;
    if (!aresetn) begin
      cfg_addr <= sgq_pkg::RST_ADDR;
      cfg_service <= sgq_pkg::RST_SERVICE;
      cfg_zsopt <= sgq_pkg::RST_ZSOPT;
      cfg_count <= sgq_pkg::RST_COUNT;
      op_status <= 8'h00;
      err_status <= 8'h00;
      for (int i = 0; i < NUM_GROUPS; i++) begin
        values[i] <= 32'h0;
      end
    end else if (wr_go) begin
      if (wr_off == sgq_pkg::REG_CONFIG) begin
        m = merge({5'h0, cfg_count, 6'h0, cfg_zsopt, cfg_service, 4'h0, cfg_addr}, s_axi_wdata, s_axi_wstrb);
        cfg_addr <= m[sgq_pkg::CFG_ADDR_LSB +: 12];
        cfg_service <= m[sgq_pkg::CFG_SERVICE_BIT];
        cfg_zsopt <= m[sgq_pkg::CFG_ZSOPT_BIT];
        cfg_count <= m[sgq_pkg::CFG_COUNT_LSB +: 3];
      end else if (wr_off == sgq_pkg::REG_STATUS_BYTES) begin
        m = merge({16'h0, err_status, op_status}, s_axi_wdata, s_axi_wstrb);
        op_status <= m[7:0];
        err_status <= {sgq_pkg::ERR_UNUSED_MASK, m[sgq_pkg::ST_ERR_LSB +: 7]};
      end else if (wr_off >= sgq_pkg::REG_VALUE_BASE) begin
        for (int i = 0; i < NUM_GROUPS; i++) begin
          if (wr_off == sgq_pkg::REG_VALUE_BASE + 8'(4 * i)) begin
            values[i] <= merge(values[i], s_axi_wdata, s_axi_wstrb);
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sgq_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? sgq_pkg::RESP_OKAY : sgq_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  sgq_pkg::sgq_tx_type tx_state;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= sgq_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= sgq_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0;
      if (s_axi_araddr[31:8] != 24'h0 || rd_off[1:0] != 2'h0) begin
        s_axi_rresp <= sgq_pkg::RESP_SLVERR;
      end else if (rd_off == sgq_pkg::REG_CONFIG) begin
        s_axi_rdata <= {5'h0, cfg_count, 6'h0, cfg_zsopt, cfg_service, 4'h0, cfg_addr};
      end else if (rd_off == sgq_pkg::REG_STATUS_BYTES) begin
        s_axi_rdata <= {16'h0, err_status, op_status};
      end else if (rd_off == sgq_pkg::REG_STATE) begin
        s_axi_rdata <= {8'h0, drop_count, 7'h0, (tx_state != sgq_pkg::T_IDLE), 6'h0, gas_mode};
      end else if (rd_off >= sgq_pkg::REG_VALUE_BASE && rd_off < sgq_pkg::REG_VALUE_BASE + 8'(4 * NUM_GROUPS)) begin
        s_axi_rdata <= values[3'((rd_off - sgq_pkg::REG_VALUE_BASE) >> 2)];
      end else begin
        s_axi_rresp <= sgq_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // frame parser
  // ----------------------------------------
  sgq_pkg::sgq_parse_type p_state;
  logic is_ctl;
  logic [1:0] ndig;
  logic [9:0] addr_val;
  logic spc_seen;
  logic [1:0] letter_mode;
  logic use_etx;
  logic [7:0] rx_sum;
  logic [3:0] ck_hi;
  logic [9:0] cfg_bin;
  logic addr_ok;
  logic [4:0] hv;
  logic is_digit;
  logic accept;
  logic drop;
  logic req_start;
  logic req_etx;

  assign cfg_bin = 10'(cfg_addr[11:8]) * 10'd100 + 10'(cfg_addr[7:4]) * 10'd10 + 10'(cfg_addr[3:0]);
  // a request with no address digits must not carry a space either
  assign addr_ok = (ndig == 2'h0) ? (is_ctl || !spc_seen) : (addr_val == cfg_bin);
  assign hv = hex_val(rx_data);
  assign is_digit = rx_data >= 8'h30 && rx_data <= 8'h39;

  always_ff @(posedge aclk) begin
    accept <= 1'b0;
    drop <= 1'b0;
    if (!aresetn) begin
      p_state <= sgq_pkg::P_IDLE;
      is_ctl <= 1'b0;
      ndig <= 2'h0;
      addr_val <= 10'h0;
      spc_seen <= 1'b0;
      letter_mode <= sgq_pkg::MODE_SAMPLE;
      use_etx <= 1'b0;
      rx_sum <= 8'h0;
      ck_hi <= 4'h0;
    end else if (rx_valid) begin
      rx_sum <= rx_sum ^ rx_data;
      if (rx_data == sgq_pkg::CH_STX) begin
        p_state <= sgq_pkg::P_C1;
        rx_sum <= rx_data;
        ndig <= 2'h0;
        addr_val <= 10'h0;
        spc_seen <= 1'b0;
        drop <= (p_state != sgq_pkg::P_IDLE);
      end else begin
        case (p_state)
          sgq_pkg::P_C1: begin
            is_ctl <= (rx_data == sgq_pkg::CH_CTL_C1);
            p_state <= (rx_data == sgq_pkg::CH_CTL_C1 || rx_data == sgq_pkg::CH_REQ_C1) ? sgq_pkg::P_C2 : sgq_pkg::P_IDLE;
            drop <= !(rx_data == sgq_pkg::CH_CTL_C1 || rx_data == sgq_pkg::CH_REQ_C1);
          end
          sgq_pkg::P_C2: begin
            if (rx_data == (is_ctl ? sgq_pkg::CH_CTL_C2 : sgq_pkg::CH_REQ_C2)) begin
              p_state <= sgq_pkg::P_BODY;
            end else begin
              p_state <= sgq_pkg::P_IDLE;
              drop <= 1'b1;
            end
          end
          sgq_pkg::P_BODY: begin
            if (is_digit && ndig != 2'h3) begin
              ndig <= ndig + 2'h1;
              addr_val <= 10'(addr_val * 4'd10) + {6'h0, rx_data[3:0]};
            end else if (rx_data == sgq_pkg::CH_SP) begin
              spc_seen <= 1'b1;
            end else if (is_ctl && (rx_data == sgq_pkg::CH_LET_ZERO || rx_data == sgq_pkg::CH_LET_SPAN ||
                rx_data == sgq_pkg::CH_LET_SAMPLE)) begin
              letter_mode <= (rx_data == sgq_pkg::CH_LET_ZERO) ? sgq_pkg::MODE_ZERO :
                (rx_data == sgq_pkg::CH_LET_SPAN) ? sgq_pkg::MODE_SPAN : sgq_pkg::MODE_SAMPLE;
              p_state <= sgq_pkg::P_TERM;
            end else if (!is_ctl && (rx_data == sgq_pkg::CH_CR || rx_data == sgq_pkg::CH_ETX) && addr_ok) begin
              use_etx <= (rx_data == sgq_pkg::CH_ETX);
              accept <= (rx_data == sgq_pkg::CH_CR);
              p_state <= (rx_data == sgq_pkg::CH_ETX) ? sgq_pkg::P_CK1 : sgq_pkg::P_IDLE;
            end else begin
              p_state <= sgq_pkg::P_IDLE;
              drop <= 1'b1;
            end
          end
          sgq_pkg::P_TERM: begin
            if ((rx_data == sgq_pkg::CH_CR || rx_data == sgq_pkg::CH_ETX) && addr_ok) begin
              use_etx <= (rx_data == sgq_pkg::CH_ETX);
              accept <= (rx_data == sgq_pkg::CH_CR);
              p_state <= (rx_data == sgq_pkg::CH_ETX) ? sgq_pkg::P_CK1 : sgq_pkg::P_IDLE;
            end else begin
              p_state <= sgq_pkg::P_IDLE;
              drop <= 1'b1;
            end
          end
          sgq_pkg::P_CK1: begin
            rx_sum <= rx_sum;
            ck_hi <= hv[3:0];
            p_state <= hv[4] ? sgq_pkg::P_IDLE : sgq_pkg::P_CK2;
            drop <= hv[4];
          end
          sgq_pkg::P_CK2: begin
            rx_sum <= rx_sum;
            accept <= !hv[4] && ({ck_hi, hv[3:0]} == rx_sum);
            drop <= hv[4] || ({ck_hi, hv[3:0]} != rx_sum);
            p_state <= sgq_pkg::P_IDLE;
          end
          default: begin
            p_state <= sgq_pkg::P_IDLE;
          end
        endcase
      end
    end
  end

  assign req_start = accept && !is_ctl && (tx_state == sgq_pkg::T_IDLE);
  assign req_etx = use_etx;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gas_mode <= sgq_pkg::MODE_SAMPLE;
    end else if (accept && is_ctl && !cfg_service && cfg_zsopt) begin
      gas_mode <= letter_mode;
    end
  end

  // drops saturate; a request met by a busy transmitter counts as dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drop_count <= 8'h0;
    end else if ((drop || (accept && !is_ctl && !req_start)) && drop_count != 8'hff) begin
      drop_count <= drop_count + 8'h1;
    end
  end

  // ----------------------------------------
  // reply transmitter
  // ----------------------------------------
  logic [4:0] idx;
  logic [2:0] grp;
  logic [2:0] ngrp;
  logic tx_etx;
  logic [11:0] rep_addr;
  logic [7:0] tx_sum;
  logic [31:0] cur_val;
  logic [7:0] cur_byte;
  logic load;
  logic last_byte;

  assign cur_val = values[grp];
  assign load = (tx_state != sgq_pkg::T_IDLE) && (!tx_valid || tx_ready);

  always_comb begin
    cur_byte = sgq_pkg::CH_SP;
    last_byte = 1'b0;
    case (tx_state)
      sgq_pkg::T_HEAD: begin
        case (idx)
          5'h0: cur_byte = sgq_pkg::CH_STX;
          5'h1: cur_byte = sgq_pkg::CH_REP_C1;
          5'h2: cur_byte = sgq_pkg::CH_REP_C2;
          5'h3: cur_byte = sgq_pkg::CH_ZERO;
          default: cur_byte = sgq_pkg::CH_ZERO + {5'h0, ngrp};
        endcase
      end
      sgq_pkg::T_GRP: begin
        if (idx == 5'h1) cur_byte = sgq_pkg::CH_ZERO + {4'h0, rep_addr[11:8]};
        else if (idx == 5'h2) cur_byte = sgq_pkg::CH_ZERO + {4'h0, rep_addr[7:4]};
        else if (idx == 5'h3) cur_byte = sgq_pkg::CH_ZERO + {4'h0, rep_addr[3:0]};
        else if (idx == 5'h5) cur_byte = cur_val[sgq_pkg::VAL_MSIGN_BIT] ? sgq_pkg::CH_MINUS : sgq_pkg::CH_PLUS;
        else if (idx >= 5'h6 && idx <= 5'h9) begin
          cur_byte = sgq_pkg::CH_ZERO + {4'h0, cur_val[sgq_pkg::VAL_MANT_LSB + 4 * (9 - int'(idx)) +: 4]};
        end else if (idx == 5'ha) begin
          cur_byte = cur_val[sgq_pkg::VAL_ESIGN_BIT] ? sgq_pkg::CH_MINUS : sgq_pkg::CH_PLUS;
        end else if (idx == 5'hb) cur_byte = sgq_pkg::CH_ZERO + {4'h0, cur_val[sgq_pkg::VAL_EXP_LSB + 4 +: 4]};
        else if (idx == 5'hc) cur_byte = sgq_pkg::CH_ZERO + {4'h0, cur_val[sgq_pkg::VAL_EXP_LSB +: 4]};
        else if (idx == 5'he) cur_byte = hex_char(op_status[7:4]);
        else if (idx == 5'hf) cur_byte = hex_char(op_status[3:0]);
        else if (idx == 5'h11) cur_byte = hex_char(err_status[7:4]);
        else if (idx == 5'h12) cur_byte = hex_char(err_status[3:0]);
        else if (idx >= 5'h14) cur_byte = sgq_pkg::CH_ZERO;
      end
      sgq_pkg::T_TAIL: begin
        if (idx == 5'h0) begin
          cur_byte = tx_etx ? sgq_pkg::CH_ETX : sgq_pkg::CH_CR;
          last_byte = !tx_etx;
        end else if (idx == 5'h1) begin
          cur_byte = hex_char(tx_sum[7:4]);
        end else begin
          cur_byte = hex_char(tx_sum[3:0]);
          last_byte = 1'b1;
        end
      end
      default: cur_byte = sgq_pkg::CH_SP;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state <= sgq_pkg::T_IDLE;
      idx <= 5'h0;
      grp <= 3'h0;
      ngrp <= 3'h1;
      tx_etx <= 1'b0;
      rep_addr <= 12'h0;
      tx_sum <= 8'h0;
    end else if (tx_state == sgq_pkg::T_IDLE) begin
      if (req_start) begin
        tx_state <= sgq_pkg::T_HEAD;
        idx <= 5'h0;
        grp <= 3'h0;
        // count register is clamped to the groups actually held
        ngrp <= (cfg_count == 3'h0) ? 3'h1 : ((32'(cfg_count) > NUM_GROUPS) ? 3'(NUM_GROUPS) : cfg_count);
        tx_etx <= req_etx;
        rep_addr <= cfg_addr;
        tx_sum <= 8'h0;
      end
    end else if (load) begin
      if (!(tx_state == sgq_pkg::T_TAIL && idx != 5'h0)) begin
        tx_sum <= tx_sum ^ cur_byte;
      end
      idx <= idx + 5'h1;
      if (last_byte) begin
        tx_state <= sgq_pkg::T_IDLE;
      end else if (tx_state == sgq_pkg::T_HEAD && idx == sgq_pkg::HEAD_LAST) begin
        tx_state <= sgq_pkg::T_GRP;
        idx <= 5'h0;
      end else if (tx_state == sgq_pkg::T_GRP && idx == sgq_pkg::GROUP_LAST) begin
        idx <= 5'h0;
        grp <= grp + 3'h1;
        rep_addr <= bcd_inc(rep_addr);
        if (grp + 3'h1 == ngrp) begin
          tx_state <= sgq_pkg::T_TAIL;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h0;
    end else if (load) begin
      tx_valid <= 1'b1;
      tx_data <= cur_byte;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end
endmodule

// ---- src/sgq_pkg.sv ----
// package for the serial gas query interpreter: offsets, fields, characters, codes
// assumes a 32-bit axi4-lite master and a byte-wide receive/transmit stream
package sgq_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_STATUS_BYTES = 8'h04;
  localparam logic [7:0] REG_STATE = 8'h08;
  localparam logic [7:0] REG_VALUE_BASE = 8'h20;
  localparam int NUM_VALUES = 7;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int CFG_ADDR_LSB = 0;
  localparam int CFG_SERVICE_BIT = 16;
  localparam int CFG_ZSOPT_BIT = 17;
  localparam int CFG_COUNT_LSB = 24;
  localparam logic [11:0] RST_ADDR = 12'h000;
  localparam logic [2:0] RST_COUNT = 3'h7;
  localparam logic RST_SERVICE = 1'b0;
  localparam logic RST_ZSOPT = 1'b1;
  localparam int ST_ERR_LSB = 8;
  localparam logic ERR_UNUSED_MASK = 1'b0;
  localparam int STATE_BUSY_BIT = 8;
  localparam int STATE_DROP_LSB = 16;
  localparam int VAL_MSIGN_BIT = 31;
  localparam int VAL_MANT_LSB = 12;
  localparam int VAL_ESIGN_BIT = 11;
  localparam int VAL_EXP_LSB = 0;
  // ----------------------------------------
  // gas modes and characters
  // ----------------------------------------
  localparam logic [1:0] MODE_SAMPLE = 2'h0;
  localparam logic [1:0] MODE_ZERO = 2'h1;
  localparam logic [1:0] MODE_SPAN = 2'h2;
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_CTL_C1 = 8'h53;
  localparam logic [7:0] CH_CTL_C2 = 8'h54;
  localparam logic [7:0] CH_REQ_C1 = 8'h44;
  localparam logic [7:0] CH_REQ_C2 = 8'h41;
  localparam logic [7:0] CH_REP_C1 = 8'h4d;
  localparam logic [7:0] CH_REP_C2 = 8'h44;
  localparam logic [7:0] CH_LET_ZERO = 8'h4e;
  localparam logic [7:0] CH_LET_SPAN = 8'h4b;
  localparam logic [7:0] CH_LET_SAMPLE = 8'h4d;
  // ----------------------------------------
  // reply layout and axi response codes
  // ----------------------------------------
  localparam logic [4:0] HEAD_LAST = 5'h4;
  localparam logic [4:0] GROUP_LAST = 5'h1d;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef enum logic [6:0] {
    P_IDLE = 7'h01, P_C1 = 7'h02, P_C2 = 7'h04, P_BODY = 7'h08,
    P_TERM = 7'h10, P_CK1 = 7'h20, P_CK2 = 7'h40
  } sgq_parse_type;
  typedef enum logic [3:0] {
    T_IDLE = 4'h1, T_HEAD = 4'h2, T_GRP = 4'h4, T_TAIL = 4'h8
  } sgq_tx_type;
endpackage

// ---- dv/sgq_top_chk.sv ----
// assertions over the interpreter's top-level ports
// assumes binding onto sgq_top; one clock, synchronous active-low reset
`timescale 1ns/1ps
module sgq_top_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_valid,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic [1:0] gas_mode
);
  // ----------------
  // port relations
  // ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_write_taken;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence
  sequence s_tx_stall;
    tx_valid && !tx_ready;
  endsequence
  chk_write_answer: assert property (s_write_taken |=> s_axi_bvalid)
    else $error("write not answered");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_tx_byte_hold: assert property (s_tx_stall |=> tx_valid && $stable(tx_data))
    else $error("tx byte lost while stalled");
  chk_reply_start: assert property ($rose(tx_valid) |-> tx_data == sgq_pkg::CH_STX && $past(rx_valid, 3))
    else $error("reply start wrong");
  chk_mode_legal: assert property (gas_mode != 2'h3)
    else $error("illegal gas mode");
  chk_mode_cause: assert property ($changed(gas_mode) |-> $past(rx_valid, 2))
    else $error("gas mode changed without a frame");
endmodule

// ---- dv/sgq_host_model.sv ----
// host side of the serial link: frames commands, collects reply bytes
// assumes a byte stream on aclk; tx_ready stalls one cycle in three
`timescale 1ns/1ps
module sgq_host_model (
  input wire logic aclk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  // ----------------
  // link behaviour
  // ----------------
  logic [7:0] got[$];
  logic [1:0] phase = 2'h0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hff;
    tx_ready = 1'b0;
  end
  // stalls so the transmitter has to hold its byte
  always @(posedge aclk) begin
    phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    tx_ready <= (phase != 2'h2);
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  task automatic send(input logic [7:0] b);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_data <= ~b; // idle line must not echo the byte
  endtask
  task automatic frame(input string body, input bit etx, input bit bad);
    logic [7:0] ck;
    ck = 8'h02;
    send(8'h02);
    foreach (body[i]) begin
      send(body[i]);
      ck = ck ^ body[i];
    end
    if (etx) begin
      ck = ck ^ 8'h03 ^ {7'h0, bad};
      send(8'h03);
      send(hx(ck[7:4]));
      send(hx(ck[3:0]));
    end else begin
      send(8'h0d);
    end
  endtask
endmodule

// ---- dv/serial_gas_data_query_protocol_test.sv ----
// self-checking bench for the serial gas query interpreter
// assumes sgq_top, its checker and the host model compiled before it
`timescale 1ns/1ps
module serial_gas_data_query_protocol_test;
  // ----------------
  // harness
  // ----------------
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_valid, tx_valid, tx_ready;
  logic [1:0] s_axi_bresp, s_axi_rresp, gas_mode;
  logic [7:0] rx_data, tx_data;
  int n_fail = 0, num_checks = 0;
  always #4 aclk = ~aclk;
  sgq_top i_sgq_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_valid, .rx_data, .tx_valid,
    .tx_data, .tx_ready, .gas_mode);
  sgq_host_model i_sgq_host_model (.aclk, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready);
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check({30'h0, s_axi_bresp}, 32'h0, "write response");
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h00, d, r);
    check(d, 32'h0702_0000, "config reset");
    rd(8'h10, d, r);
    check({30'h0, r}, 32'h2, "unmapped read");
    wr(8'h04, 32'h0000_8403);
    rd(8'h04, d, r);
    check(d, 32'h0000_0403, "status bytes");
    wr(8'h20, 32'h0456_7802);
    wr(8'h24, 32'h8538_4006);
    wr(8'h00, 32'h0202_0005);
    $display("registers done");
  endtask
  task automatic t_mode(input string body, input logic [1:0] m, input bit etx);
    i_sgq_host_model.frame(body, etx, 1'b0);
    repeat (4) @(posedge aclk);
    check({30'h0, gas_mode}, {30'h0, m}, "gas mode");
    $display("control done");
  endtask
  task automatic t_query(input string body, input bit etx);
    string e;
    logic [7:0] ck;
    int n;
    e = "\002MD02 005 +4567-02 03 04 0000000000 006 -5384+06 03 04 0000000000";
    ck = 8'h0;
    foreach (e[i]) ck = ck ^ e[i];
    e = etx ? {e, "\003", $sformatf("%02X", ck ^ 8'h03)} : {e, "\015"};
    i_sgq_host_model.got.delete();
    i_sgq_host_model.frame(body, etx, 1'b0);
    for (n = 0; n < 3000 && (i_sgq_host_model.got.size() < e.len() || tx_valid); n++) @(posedge aclk);
    check(32'(n < 3000), 32'h1, "reply timeout");
    check(32'(i_sgq_host_model.got.size()), 32'(e.len()), "reply length");
    foreach (e[i]) check({24'h0, i_sgq_host_model.got[i]}, {24'h0, e[i]}, "reply byte");
    $display("query done");
  endtask
  task automatic t_drop(input string body, input bit etx, input bit bad);
    i_sgq_host_model.got.delete();
    i_sgq_host_model.frame(body, etx, bad);
    repeat (6) @(posedge aclk);
    check(32'(i_sgq_host_model.got.size()), 32'h0, "answered a bad frame");
    $display("drop done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_mode("ST005 N", sgq_pkg::MODE_ZERO, 1'b0);
    t_mode("STK", sgq_pkg::MODE_SPAN, 1'b1);
    t_mode("ST5M", sgq_pkg::MODE_SAMPLE, 1'b0);
    t_mode("ST007N", sgq_pkg::MODE_SAMPLE, 1'b0);
    wr(8'h00, 32'h0203_0005);
    t_mode("STN", sgq_pkg::MODE_SAMPLE, 1'b0);
    wr(8'h00, 32'h0200_0005);
    t_mode("STN", sgq_pkg::MODE_SAMPLE, 1'b0);
    wr(8'h00, 32'h0202_0005);
    t_query("DA", 1'b0);
    t_query("DA  5", 1'b1);
    t_query("D\002DA005", 1'b0);
    t_drop("DA007", 1'b0, 1'b0);
    t_drop("DA ", 1'b0, 1'b0);
    t_drop("DA", 1'b1, 1'b1);
    t_drop("DB", 1'b0, 1'b0);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    wrap_up();
  end
endmodule
bind sgq_top sgq_top_chk i_sgq_top_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .rx_valid, .tx_valid, .tx_data, .tx_ready, .gas_mode);
